// ### hdl/valve_node_params.svh
/*
  Constants of the valve output slave node: register offsets, field
  positions, reset values and timing figures. Assumes a 50 MHz clock.
*/
`ifndef VALVE_NODE_PARAMS_SVH
`define VALVE_NODE_PARAMS_SVH

// ==========================================================
// register offsets (byte addresses, one word each)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0C
`define REG_OUTPUTS     8'h10
`define REG_DIAG_STD    8'h14
`define REG_DIAG_OUT    8'h18

// ==========================================================
// fields and reset values
`define CTRL_RESET      4'h0
`define MASK_RESET      3'h0
`define IRQ_LINK_FAIL   0
`define IRQ_SUPPLY      1
`define IRQ_OUT_FAULT   2
`define DIP_BAUD        0
`define DIP_LEN_LO      2
`define DIP_LEN_HI      3
`define PARAM_FREEZE    3
`define STD_ELEC        0
`define STD_VALVE       1
`define STD_LINK        7
`define OUT_SLOT        4

// ==========================================================
// timing
`define CLK_HZ          50000000
`define BAUD_LOW_HZ     125000
`define BAUD_HIGH_HZ    250000
`define BIT_CYC_LOW     (`CLK_HZ / `BAUD_LOW_HZ)
`define BIT_CYC_HIGH    (`CLK_HZ / `BAUD_HIGH_HZ)
`define BLINK_HALF_MS   500
`define BLINK_HALF_CYC  ((`CLK_HZ / 1000) * `BLINK_HALF_MS)
`define LINK_TO_MS      20
`define LINK_TO_CYC     ((`CLK_HZ / 1000) * `LINK_TO_MS)

`endif

// ### hdl/valve_node_pkg.sv
/*
  Types of the valve output slave node. Assumes the constants header
  is available on the include path.
*/
package valve_node_pkg;

  // ========================================================
  // configuration latched from the switches
  typedef struct packed {
    logic [3:0] addr;
    logic       baud_high;
    logic [1:0] len_m1;
  } cfg_t;

  // ========================================================
  // link side carriers
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } link_byte_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } link_rsp_t;

endpackage : valve_node_pkg

// ### hdl/valve_output_slave_node.sv
/*
  Valve output slave node: AHB-Lite register slave, link output and
  diagnosis byte handling, switch latch, valve drive and indicators.
  Assumes a link protocol engine on the same clock presents bytes and
  cycle markers; switch and monitor pins are asynchronous.
*/
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "valve_node_params.svh"

module valve_output_slave_node #(
  parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC,
  parameter int unsigned LINK_TO_CYC    = `LINK_TO_CYC
) (
  // clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    resetn_in,
  // ahb-lite slave
  input  wire logic                    hsel_in,
  input  wire logic [31:0]             haddr_in,
  input  wire logic [1:0]              htrans_in,
  input  wire logic                    hwrite_in,
  input  wire logic [2:0]              hsize_in,
  input  wire logic [31:0]             hwdata_in,
  input  wire logic                    hready_in,
  output logic                         hreadyout_out,
  output logic [31:0]                  hrdata_out,
  output logic                         hresp_out,
  output logic                         irq_out,
  // switches and monitor pins
  input  wire logic [3:0]              address_selector_switch_in,
  input  wire logic [3:0]              config_dip_switch_in,
  input  wire logic                    elec_ok_in,
  input  wire logic                    elec_present_in,
  input  wire logic                    valve_ok_in,
  input  wire logic                    valve_present_in,
  input  wire logic [23:0]             short_mon_in,
  input  wire logic [23:0]             open_mon_in,
  // link engine
  input  valve_node_pkg::link_byte_t   link_out_byte_in,
  input  valve_node_pkg::link_byte_t   link_diag_req_in,
  input  valve_node_pkg::link_byte_t   link_param_in,
  input  wire logic                    link_cycle_end_in,
  input  wire logic                    link_cfg_err_in,
  input  wire logic [7:0]              link_in_range_len_in,
  output valve_node_pkg::link_rsp_t    link_diag_rsp_out,
  output logic [7:0]                   link_in_len_out,
  output logic [2:0]                   link_diag_len_out,
  output logic                         bit_tick_out,
  output logic                         baud_high_out,
  // valves and indicators
  output logic [23:0]                  valve_out,
  output logic                         led_link_red_out,
  output logic                         led_elec_out,
  output logic                         led_valve_out
);
  import valve_node_pkg::*;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  // ========================================================
  // pin synchronisers
  logic [59:0] pin_s1_ff, pin_s2_ff;
  logic [3:0]  sup_s;
  logic [23:0] short_s, open_s;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= {address_selector_switch_in, config_dip_switch_in,
                    elec_ok_in, elec_present_in, valve_ok_in,
                    valve_present_in, short_mon_in, open_mon_in};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  assign sup_s   = pin_s2_ff[51:48];
  assign short_s = pin_s2_ff[47:24];
  assign open_s  = pin_s2_ff[23:0];

  // ========================================================
  // power-up switch latch
  cfg_t       cfg_ff;
  logic [1:0] cfg_cnt_ff;
  logic       cfg_done_ff;

  // wait until the synchroniser holds real pin values
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      cfg_cnt_ff  <= 2'h0;
      cfg_done_ff <= 1'b0;
      cfg_ff      <= '0;
    end else if (!cfg_done_ff) begin
      cfg_cnt_ff <= cfg_cnt_ff + 2'h1;
      if (cfg_cnt_ff == 2'h2) begin
        cfg_done_ff      <= 1'b1;
        cfg_ff.addr      <= pin_s2_ff[59:56];
        cfg_ff.baud_high <= pin_s2_ff[52 + `DIP_BAUD];
        cfg_ff.len_m1    <= {pin_s2_ff[52 + `DIP_LEN_HI],
                             pin_s2_ff[52 + `DIP_LEN_LO]};
      end
    end
  end

  // ========================================================
  // addressing
  logic [3:0] auto_addr_ff, eff_addr, addr_m1;
  logic       active;
  logic [7:0] out_base, diag_base, out_idx, diag_idx;

  assign eff_addr = (cfg_ff.addr == 4'h0) ? auto_addr_ff
                                          : cfg_ff.addr;
  assign addr_m1  = eff_addr - 4'h1;
  assign active   = cfg_done_ff && (eff_addr != 4'h0);
  assign out_base = {2'h0, addr_m1, 2'h0};
  assign diag_base = link_in_range_len_in + {2'h0, addr_m1, 2'h0}
                     + {4'h0, addr_m1};
  assign out_idx  = link_out_byte_in.addr - out_base;
  assign diag_idx = link_diag_req_in.addr - diag_base;

  // ========================================================
  // link parameters, watchdog and exchange state
  logic        param_got_ff, freeze_ff, link_fail_ff, exch_ok_ff;
  logic [31:0] wd_cnt_ff;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      param_got_ff <= 1'b0;
      freeze_ff    <= 1'b0;
    end else if (link_param_in.valid) begin
      param_got_ff <= 1'b1;
      freeze_ff    <= link_param_in.data[`PARAM_FREEZE];
    end
  end

  // failure only after a first exchange, so start-up is not a fault
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      wd_cnt_ff    <= 32'h0;
      link_fail_ff <= 1'b0;
    end else if (link_cycle_end_in) begin
      wd_cnt_ff    <= 32'h0;
      link_fail_ff <= 1'b0;
    end else if (exch_ok_ff || link_fail_ff) begin
      if (wd_cnt_ff == LINK_TO_CYC - 1) begin
        link_fail_ff <= 1'b1;
      end else begin
        wd_cnt_ff <= wd_cnt_ff + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      exch_ok_ff <= 1'b0;
    end else if (link_cfg_err_in || link_fail_ff || !active) begin
      exch_ok_ff <= 1'b0;
    end else if (link_cycle_end_in && param_got_ff) begin
      exch_ok_ff <= 1'b1;
    end
  end

  // ========================================================
  // output bytes and valve drive
  logic [3:0][7:0] out_buf_ff;
  logic [23:0]     len_mask;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      out_buf_ff <= '0;
    end else if (link_out_byte_in.valid && active &&
                 out_idx <= {6'h0, cfg_ff.len_m1}) begin
      out_buf_ff[out_idx[1:0]] <= link_out_byte_in.data;
    end
  end

  // bytes beyond the configured length never reach a valve
  assign len_mask = {{8{cfg_ff.len_m1 >= 2'h2}},
                     {8{cfg_ff.len_m1 >= 2'h1}}, 8'hFF};

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      valve_out <= 24'h0;
    end else if (link_fail_ff) begin
      if (!freeze_ff) begin
        valve_out <= 24'h0;
      end
    end else if (link_cycle_end_in && active) begin
      valve_out <= {out_buf_ff[2], out_buf_ff[1], out_buf_ff[0]}
                   & len_mask;
    end
  end

  // ========================================================
  // diagnosis capture and answer
  logic [7:0]  diag_std_ff;
  logic [31:0] diag_out_ff;
  logic        elec_bad, valve_bad;

  assign elec_bad  = !sup_s[3];
  assign valve_bad = !sup_s[1];

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      diag_std_ff <= 8'h0;
      diag_out_ff <= 32'h0;
    end else if (link_cycle_end_in) begin
      diag_std_ff <= {link_fail_ff, 5'h0, valve_bad, elec_bad};
      diag_out_ff <= {8'h00, (valve_out & short_s) |
                      (~valve_out & open_s)};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      link_diag_rsp_out <= '0;
    end else begin
      link_diag_rsp_out.valid <= link_diag_req_in.valid && active &&
                                 diag_idx <= {6'h0, cfg_ff.len_m1} + 8'h1;
      unique case (diag_idx[2:0])
        3'h0:    link_diag_rsp_out.data <= diag_std_ff;
        3'h1:    link_diag_rsp_out.data <= diag_out_ff[7:0];
        3'h2:    link_diag_rsp_out.data <= diag_out_ff[15:8];
        3'h3:    link_diag_rsp_out.data <= diag_out_ff[23:16];
        3'h4:    link_diag_rsp_out.data <= diag_out_ff[31:24];
        default: link_diag_rsp_out.data <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      link_in_len_out   <= 8'h0;
      link_diag_len_out <= 3'h0;
    end else begin
      link_in_len_out   <= 8'h0;
      link_diag_len_out <= {1'b0, cfg_ff.len_m1} + 3'h2;
    end
  end

  // ========================================================
  // bit rate tick
  logic [8:0] bit_cnt_ff, bit_top;

  assign bit_top = cfg_ff.baud_high ? 9'(`BIT_CYC_HIGH - 1)
                                    : 9'(`BIT_CYC_LOW - 1);
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      bit_cnt_ff    <= 9'h0;
      bit_tick_out  <= 1'b0;
      baud_high_out <= 1'b0;
    end else begin
      baud_high_out <= cfg_ff.baud_high;
      bit_tick_out  <= cfg_done_ff && bit_cnt_ff == bit_top;
      if (!cfg_done_ff || bit_cnt_ff == bit_top) begin
        bit_cnt_ff <= 9'h0;
      end else begin
        bit_cnt_ff <= bit_cnt_ff + 9'h1;
      end
    end
  end

  // ========================================================
  // indicators
  logic [31:0] blink_cnt_ff;
  logic        blink_ff;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      blink_cnt_ff <= 32'h0;
      blink_ff     <= 1'b0;
    end else if (blink_cnt_ff == BLINK_HALF_CYC - 1) begin
      blink_cnt_ff <= 32'h0;
      blink_ff     <= !blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      led_elec_out     <= 1'b0;
      led_valve_out    <= 1'b0;
      led_link_red_out <= 1'b1;
    end else begin
      led_elec_out  <= sup_s[2] && (sup_s[3] || blink_ff);
      led_valve_out <= sup_s[0] && (sup_s[1] || blink_ff);
      led_link_red_out <= !exch_ok_ff;
    end
  end

  // ========================================================
  // interrupts
  logic [2:0] irq_stat_ff, irq_mask_ff, irq_evt;
  logic       fail_d_ff, sup_bad_d_ff, clr_stat;

  assign irq_evt = {link_cycle_end_in && (|diag_out_ff[23:0] == 1'b0) &&
                    (|((valve_out & short_s) | (~valve_out & open_s))),
                    cfg_done_ff && (elec_bad || valve_bad) && !sup_bad_d_ff,
                    link_fail_ff && !fail_d_ff};

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      irq_stat_ff  <= 3'h0;
      fail_d_ff    <= 1'b0;
      sup_bad_d_ff <= 1'b0;
      irq_out      <= 1'b0;
    end else begin
      fail_d_ff    <= link_fail_ff;
      // pins read as faulty until the latch, so no edge before it
      sup_bad_d_ff <= cfg_done_ff && (elec_bad || valve_bad);
      // a new event wins over the read that clears
      irq_stat_ff  <= (clr_stat ? 3'h0 : irq_stat_ff) | irq_evt;
      irq_out      <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ========================================================
  // ahb-lite slave, zero wait states
  logic       ap_valid, wr_pend_ff;
  logic [7:0] wr_addr_ff, ap_addr;
  logic [31:0] rd_mux;

  assign ap_valid = hsel_in && htrans_in[1] && hready_in &&
                    hsize_in == 3'h2;
  assign ap_addr  = {haddr_in[7:2], 2'h0};
  assign clr_stat = ap_valid && !hwrite_in && ap_addr == `REG_IRQ_STAT;

  always_comb begin
    rd_mux = 32'h0;
    unique case (ap_addr)
      `REG_CTRL:     rd_mux = {28'h0, auto_addr_ff};
      `REG_STATUS:   rd_mux = {19'h0, exch_ok_ff, link_fail_ff,
                               freeze_ff, param_got_ff,
                               cfg_ff.addr == 4'h0, cfg_done_ff,
                               cfg_ff.len_m1, cfg_ff.baud_high,
                               cfg_ff.addr};
      `REG_IRQ_STAT: rd_mux = {29'h0, irq_stat_ff};
      `REG_IRQ_MASK: rd_mux = {29'h0, irq_mask_ff};
      `REG_OUTPUTS:  rd_mux = {8'h0, valve_out};
      `REG_DIAG_STD: rd_mux = {24'h0, diag_std_ff};
      `REG_DIAG_OUT: rd_mux = diag_out_ff;
      default:       rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      wr_pend_ff    <= 1'b0;
      wr_addr_ff    <= 8'h0;
      hrdata_out    <= 32'h0;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      wr_pend_ff    <= ap_valid && hwrite_in;
      wr_addr_ff    <= ap_addr;
      hrdata_out    <= (ap_valid && !hwrite_in) ? rd_mux : 32'h0;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      auto_addr_ff <= `CTRL_RESET;
      irq_mask_ff  <= `MASK_RESET;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == `REG_CTRL) begin
        auto_addr_ff <= hwdata_in[3:0];
      end
      if (wr_addr_ff == `REG_IRQ_MASK) begin
        irq_mask_ff <= hwdata_in[2:0];
      end
    end
  end

  // ========================================================
  // checks
  a_cfg_held: assert property (
    cfg_done_ff |=> $stable(cfg_ff) && cfg_done_ff)
    else $error("switch configuration changed after latch");
  a_diag_length: assert property (
    cfg_done_ff ##1 cfg_done_ff |->
      link_diag_len_out == {1'b0, $past(cfg_ff.len_m1)} + 3'h2)
    else $error("diagnosis length differs from output length plus one");
  a_no_input: assert property (
    link_in_len_out == 8'h0)
    else $error("node claims input process data");
  a_std_unused: assert property (
    $rose(link_cycle_end_in) ##1 1'b1 |->
      diag_std_ff[6:2] == 5'h0 && diag_std_ff[7] == $past(link_fail_ff))
    else $error("status byte layout wrong");
  a_diag_high: assert property (
    diag_out_ff[31:24] == 8'h00)
    else $error("diagnosis for missing outputs is set");
  a_fault_gate: assert property (
    link_cycle_end_in |=> diag_out_ff[23:0] ==
      (($past(valve_out) & $past(short_s)) |
       (~$past(valve_out) & $past(open_s))))
    else $error("short or open reported in wrong drive state");
  a_fail_clear: assert property (
    link_fail_ff && !freeze_ff |=> valve_out == 24'h0)
    else $error("outputs not cleared on link failure");
  a_fail_hold: assert property (
    link_fail_ff && freeze_ff |=> $stable(valve_out))
    else $error("outputs not held on link failure");
  a_link_led: assert property (
    !exch_ok_ff |=> led_link_red_out)
    else $error("link indicator dark without exchange");
  a_byte_place: assert property (
    link_out_byte_in.valid && active && out_idx == 8'h0 |=>
      out_buf_ff[0] == $past(link_out_byte_in.data))
    else $error("output byte not taken at its address");
  a_valve_map: assert property (
    link_cycle_end_in && active && !link_fail_ff &&
      cfg_ff.len_m1 == 2'h3 |=>
      valve_out == $past({out_buf_ff[2], out_buf_ff[1], out_buf_ff[0]}))
    else $error("valve outputs do not follow output bytes");

endmodule : valve_output_slave_node

// ### verification/link_master_model.sv
/*
  Behavioural link master facing the valve node: output bytes,
  parameter byte, cycle ends and diagnosis requests. Assumes each task
  is entered just after a rising edge of the node clock.
*/
`timescale 1ns/1ps
module link_master_model
  import valve_node_pkg::*;
(
  // clock
  input  wire logic                  ref_clk_in,
  // link towards the node
  input  valve_node_pkg::link_rsp_t  diag_rsp_in,
  output valve_node_pkg::link_byte_t out_byte_out,
  output valve_node_pkg::link_byte_t diag_req_out,
  output valve_node_pkg::link_byte_t param_out,
  output logic                       cycle_end_out,
  output logic                       cfg_err_out,
  output logic [7:0]                 in_range_len_out
);
  // ==========================================================
  // idle state; strobes stand for whole frames at the node's rate
  initial begin
    out_byte_out = '0;
    diag_req_out = '0;
    param_out = '0;
    cycle_end_out = 1'b0;
    cfg_err_out = 1'b0;
    in_range_len_out = 8'h0A;
  end

  // ==========================================================
  // six bytes from base-1, so both neighbours of the slot are sent
  task automatic send_out(input logic [7:0] base, input logic [47:0] v);
    for (int i = 0; i < 6; i++) begin
      out_byte_out <= '{1'b1, 8'(base - 1 + i), v[8*i +: 8]};
      @(posedge ref_clk_in);
    end
    // released lines show the inverse, not the last value
    out_byte_out <= '{1'b0, ~out_byte_out.addr, ~out_byte_out.data};
  endtask : send_out

  task automatic send_param(input logic [7:0] p);
    param_out <= '{1'b1, 8'h00, p};
    @(posedge ref_clk_in);
    param_out <= '{1'b0, 8'hFF, ~p};
  endtask : send_param

  task automatic end_cycle();
    cycle_end_out <= 1'b1;
    @(posedge ref_clk_in);
    cycle_end_out <= 1'b0;
    @(posedge ref_clk_in);
  endtask : end_cycle

  task automatic diag(input logic [7:0] a, output logic v,
                      output logic [7:0] d);
    diag_req_out <= '{1'b1, a, 8'h00};
    @(posedge ref_clk_in);
    diag_req_out <= '{1'b0, ~a, 8'hFF};
    // the answer stands for the cycle after the request edge
    @(posedge ref_clk_in);
    v = diag_rsp_in.valid;
    d = diag_rsp_in.data;
  endtask : diag

  task automatic set_cfg_err(input logic e);
    cfg_err_out <= e;
  endtask : set_cfg_err
endmodule : link_master_model

// ### verification/tb_top.sv
/*
  Bench for the valve output slave node: AHB register tasks, a link
  master model and two configuration passes (manual and automatic
  address). Assumes package, header and design are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import valve_node_pkg::*;
  // ==========================================================
  // signals
  logic        clk, rstn, hsel, hwr, hrdy, hresp, irq, cend, cerr, tick;
  logic        bhigh, red, led_e, led_v, led_l, eok, epr, vok, vpr, v;
  logic [1:0]  htr;
  logic [2:0]  hsz, dlen;
  logic [31:0] hadr, hwd, hrd, rd;
  logic [3:0]  sel, dip;
  logic [4:0]  st;
  logic [23:0] sm, om, valve, ve;
  logic [7:0]  in_rng, in_len, d, db;
  link_byte_t  ob, dq, pm;
  link_rsp_t   rsp;
  int          n, t, a, len, miscompares, checks_done;

  valve_output_slave_node #(.BLINK_HALF_CYC(8), .LINK_TO_CYC(16))
    valve_output_slave_node_inst (
    .ref_clk_in(clk), .resetn_in(rstn), .hsel_in(hsel), .haddr_in(hadr),
    .htrans_in(htr), .hwrite_in(hwr), .hsize_in(hsz), .hwdata_in(hwd),
    .hready_in(hrdy), .hreadyout_out(hrdy), .hrdata_out(hrd),
    .hresp_out(hresp), .irq_out(irq), .address_selector_switch_in(sel),
    .config_dip_switch_in(dip), .elec_ok_in(eok), .elec_present_in(epr),
    .valve_ok_in(vok), .valve_present_in(vpr), .short_mon_in(sm),
    .open_mon_in(om), .link_out_byte_in(ob), .link_diag_req_in(dq),
    .link_param_in(pm), .link_cycle_end_in(cend), .link_cfg_err_in(cerr),
    .link_in_range_len_in(in_rng), .link_diag_rsp_out(rsp),
    .link_in_len_out(in_len), .link_diag_len_out(dlen),
    .bit_tick_out(tick), .baud_high_out(bhigh), .valve_out(valve),
    .led_link_red_out(red), .led_elec_out(led_e), .led_valve_out(led_v));

  link_master_model link_master_model_inst (
    .ref_clk_in(clk), .diag_rsp_in(rsp), .out_byte_out(ob),
    .diag_req_out(dq), .param_out(pm), .cycle_end_out(cend),
    .cfg_err_out(cerr), .in_range_len_out(in_rng));

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    hadr <= {24'h0, ad};
    htr <= 2'h2;
    hwr <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrd;
  endtask : ahb

  task automatic results();
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // ==========================================================
  // clock and watchdog; both passes need well under 4000 cycles
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (10000) @(posedge clk);
    miscompares++;
    results();
  end

  // ==========================================================
  // pass 0: address 2, 250k, 4 bytes, clear on fail
  // pass 1: automatic address 3, 125k, 1 byte, freeze on fail
  initial begin
    {hsel, hwr, htr, hadr, hwd, sm, om} = '0;
    {rstn, eok, epr, vok, vpr, led_l} = 6'h1E;
    hsz = 3'h2;
    for (int p = 0; p < 2; p++) begin
      a = p ? 3 : 2;
      len = p ? 1 : 4;
      st = {p[0], 1'b1, 2'(len - 1), ~p[0]};
      sel <= p ? 4'h0 : 4'h2;
      dip <= p ? 4'h0 : 4'hD;
      eok <= 1'b1;
      epr <= 1'b1;
      rstn <= 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (5) @(posedge clk);
      if (p) ahb(1, 8'h00, 32'h3, rd);
      ahb(0, 8'h04, 0, rd);
      chk(rd[8:4], st);
      dip <= 4'h6;
      sel <= 4'h9;
      ahb(0, 8'h04, 0, rd);
      chk(rd[8:4], st);
      ahb(0, 8'h40, 0, rd);
      chk(rd, 0);
      chk(hresp, 0);
      chk(in_len, 0);
      chk(dlen, len + 1);
      chk(bhigh, !p);
      do @(posedge clk); while (tick !== 1'b1);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (tick !== 1'b1);
      chk(n, p ? 400 : 200);
      ahb(1, 8'h0C, p ? 32'h1 : 32'h7, rd);
      ahb(0, 8'h0C, 0, rd);
      chk(rd, p ? 1 : 7);
      link_master_model_inst.send_param(p ? 8'h08 : 8'h00);
      link_master_model_inst.send_out(8'((a - 1) * 4), 48'hCC44332211EE);
      link_master_model_inst.end_cycle();
      link_master_model_inst.end_cycle();
      @(posedge clk);
      ve = p ? 24'h000011 : 24'h332211;
      chk(valve, ve);
      chk(red, 0);
      // a link configuration fault stops the exchange
      link_master_model_inst.set_cfg_err(1'b1);
      ahb(0, 8'h08, 0, rd);
      link_master_model_inst.set_cfg_err(1'b0);
      // driven bit 0 shorted, idle bit 1 open; the rest must not show
      sm <= 24'h000003;
      om <= 24'h000013;
      eok <= 1'b0;
      // two edges for the pin synchroniser before the cycle end
      repeat (2) @(posedge clk);
      chk(red, 1);
      link_master_model_inst.end_cycle();
      @(posedge clk);
      chk(irq, !p);
      db = 8'(10 + (a - 1) * 5);
      link_master_model_inst.diag(db, v, d);
      chk({v, d}, 9'h101);
      link_master_model_inst.diag(db + 8'h01, v, d);
      chk({v, d}, 9'h103);
      link_master_model_inst.diag(8'(db + len + 1), v, d);
      chk(v, 0);
      ahb(0, 8'h08, 0, rd);
      chk(rd[2:0], 3'h6);
      ahb(0, 8'h08, 0, rd);
      chk(rd[2:0], 3'h0);
      chk(irq, 0);
      sm <= 24'h0;
      om <= 24'h0;
      repeat (2) @(posedge clk);
      link_master_model_inst.end_cycle();
      link_master_model_inst.diag(db + 8'h01, v, d);
      chk({v, d}, 9'h100);
      t = 0;
      repeat (40) begin
        @(posedge clk);
        if (led_e !== led_l) t++;
        led_l = led_e;
      end
      chk(t >= 4, 1);
      chk(led_v, 1);
      chk(valve, p ? ve : 24'h0);
      chk(red, 1);
      chk(irq, 1);
      ahb(0, 8'h04, 0, rd);
      chk(rd[11], 1);
      epr <= 1'b0;
      // two synchroniser stages plus the indicator register
      repeat (4) @(posedge clk);
      chk(led_e, 0);
    end
    results();
  end
endmodule : tb_top
